// ---- src/dscr_pkg.sv ----
// package: register map, field positions, reset values and carriers
package dscr_pkg;
  // ---
  // register addresses on the serial host bus
  // ---
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hC6;
  localparam logic [7:0] ADDR_MODEM_SETUP = 8'hC7;
  localparam logic [7:0] ADDR_BLOCK_LOAD_PORT = 8'hC8;
  localparam logic [7:0] ADDR_TRANSMIT_WORD = 8'hCA;
  localparam logic [7:0] ADDR_TONE_DETECT_STATE = 8'hCC;
  localparam logic [7:0] ADDR_TONE_AND_GAIN_MUX = 8'hCD;
  localparam logic [7:0] ADDR_EVENT_ENABLE_MASK = 8'hCE;
  // ---
  // frame layout: address byte then one data word
  // ---
  localparam logic [4:0] ADDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  // ---
  // event flag bit positions
  // ---
  localparam int EV_LOAD_READY = 0;
  localparam int EV_DSC = 3;
  localparam int EV_DATA_READY = 6;
  localparam int EV_DATA_END = 7;
  localparam int EV_ADC1 = 8;
  localparam int EV_ADC2 = 9;
  localparam int EV_DTMF = 12;
  localparam int EV_WEATHER = 14;
  localparam int EV_SUMMARY = 15;
  localparam int EV_READ_CLEAR_LO = 2;
  localparam logic [15:0] EV_READ_CLEAR_MASK = 16'hFFFC;
  localparam logic [15:0] EV_USED_MASK = 16'h53C9;
  localparam logic [15:0] EVENT_FLAGS_RESET = 16'h0001;
  localparam logic [15:0] EVENT_MASK_RESET = 16'h0000;
  // ---
  // tone detect state fields
  // ---
  localparam int TONE_VALID_BIT = 10;
  localparam int TONE_INDEX_LO = 11;
  localparam logic [15:0] TONE_CHANGE_MASK = 16'h7C00;
  // ---
  // tone and gain multiplexed register selectors
  // ---
  localparam logic [3:0] SEL_TONE_FREQ = 4'h0;
  localparam logic [3:0] SEL_TONE_LEVEL = 4'h2;
  localparam logic [3:0] SEL_OUT1_GAIN = 4'h6;
  localparam logic [3:0] SEL_OUT2_GAIN = 4'h8;
  localparam logic [3:0] SEL_VOICE_MULT = 4'hA;
  localparam logic [3:0] SEL_FINE_ATTEN = 4'hC;
  localparam logic [11:0] LEVEL_UNITY = 12'hFFF;
  localparam logic [11:0] TONE_FREQ_RESET = 12'h000;
  localparam logic [2:0] VOICE_MULT_RESET = 3'h0;
  localparam logic [2:0] VOICE_MULT_MAX = 3'h5;
  localparam logic [3:0] FINE_ATTEN_RESET = 4'h0;
  localparam logic [3:0] FINE_ATTEN_MAX = 4'h9;
  // ---
  // block load port fields
  // ---
  localparam int LOAD_SELECT_BIT = 15;
  localparam logic [3:0] LOAD_LEVEL_PREFIX = 4'hD;
  localparam logic [2:0] BLOCK_RESET = 3'h0;
  localparam logic [3:0] WORD_PTR_RESET = 4'h0;
  // ---
  // modem setup register layout
  // ---
  typedef struct packed {
    logic frame_pattern_c_search;
    logic frame_pattern_d_search;
    logic frame_pattern_t_search;
    logic weather_decoder_direct_out;
    logic dsc_mode;
    logic raw_mode;
    logic last_data;
    logic [5:0] zero_hi;
    logic user_bit;
    logic [1:0] zero_lo;
  } dscr_modem_setup_t;
  localparam logic [15:0] MODEM_SETUP_RESET = 16'h0000;
  // ---
  // transmit data word: two flagged characters
  // ---
  typedef struct packed {
    logic skip0;
    logic [6:0] char0;
    logic skip1;
    logic [6:0] char1;
  } dscr_tx_word_t;
  localparam logic [15:0] TX_WORD_RESET = 16'h0000;
  // ---
  // write command handed from the link to the core
  // ---
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } dscr_write_t;
  // device identity shown after reset; value is arbitrary
  localparam logic [15:0] DEVICE_IDENT = 16'h5A3C;
endpackage : dscr_pkg

// ---- src/dscr_regs.sv ----
// module: host register bank with serial link front end
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - data-ready flag: tx needs word, rx word ready
// - dsc flag set on valid dsc sequence
// - load-ready high while loadable, cleared by write
// - reading flags clears bits 15..2, not 0
// - flags invalid while powersave bit set
// - weather direct-out bit passed out only; sync search ignores it
// - dsc mode bit selects modem operation
// - raw receive: search sync, deliver 16-bit words
// - raw transmit: send 16-bit words, host formats
// - repeat current word unless new one loaded
// - formatted mode skips flagged characters
// - tone state shows identity after reset
// - tone-valid bit with four-bit tone index
// - tone change sets dtmf flag; tx reads zero
// - selector 0: tone frequency, zero gives bias
// - new tone frequency acts immediately
// - selector 2 level, last of two writers wins
// - level write acted only when value differs from last selector 2 write
// - selectors 6 and 8 set output gains
// - selector A sets voice multiplier x1..x32
// - selector C sets two fine attenuators
// - summary bit on masked change; pin when enabled
// - load port select resets pointer, else advances
module dscr_regs
  import dscr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_serial_clock,
  input wire logic i_select_n,
  input wire logic i_command_data,
  output logic o_reply_data,
  output logic o_reply_oe,
  output logic o_interrupt_pin_n,
  input wire logic i_tx_mode,
  input wire logic i_rx_mode,
  input wire logic i_powersave,
  input wire logic i_tone_enable,
  input wire logic i_rx_word_ready,
  input wire logic i_dsc_valid,
  input wire logic i_data_end,
  input wire logic i_weather_change,
  input wire logic i_adc1_change,
  input wire logic i_adc2_change,
  input wire logic i_load_done,
  input wire logic i_tone_update,
  input wire logic i_tone_valid,
  input wire logic [3:0] i_tone_index,
  input wire logic i_word_sent,
  output dscr_pkg::dscr_modem_setup_t o_modem_setup,
  output logic o_sync_search,
  output logic o_flags_valid,
  output dscr_pkg::dscr_tx_word_t o_tx_word,
  output logic [1:0] o_tx_char_send,
  output logic o_load_write,
  output logic [15:0] o_load_data,
  output logic [2:0] o_load_block,
  output logic [3:0] o_load_word_ptr,
  output logic [11:0] o_tone_freq,
  output logic o_tone_active,
  output logic [11:0] o_tone_level,
  output logic o_tone_level_load,
  output logic [11:0] o_out1_gain,
  output logic [11:0] o_out2_gain,
  output logic [2:0] o_voice_mult,
  output logic [3:0] o_modulator_out_one_atten,
  output logic [3:0] o_modulator_out_two_atten
);
  import dscr_pkg::*;

  // ---
  // link side: shift in address and data
  // ---
  logic [4:0] bit_count;
  logic [22:0] shift_in;
  dscr_write_t link_write;
  logic link_write_toggle;
  logic link_read_toggle;
  logic [15:0] reply_shift;
  logic reply_drive;
  logic [15:0] snap_flags;
  logic [15:0] snap_tone;
  logic [7:0] next_addr;

  assign next_addr = {shift_in[6:0], i_command_data};

  always_ff @(posedge i_serial_clock or posedge i_select_n)
  begin
    if (i_select_n)
      bit_count <= 5'h00;
    else if (bit_count != FRAME_BITS)
      bit_count <= bit_count + 5'h01;
  end

  always_ff @(posedge i_serial_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      shift_in <= 23'h000000;
    else
      shift_in <= {shift_in[21:0], i_command_data};
  end

  // write frame complete: hand over and toggle
  always_ff @(posedge i_serial_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      link_write <= '0;
      link_write_toggle <= 1'b0;
      link_read_toggle <= 1'b0;
    end
    else if (bit_count == FRAME_BITS - 5'h01)
    begin
      if (shift_in[22:15] == ADDR_EVENT_FLAGS)
        link_read_toggle <= ~link_read_toggle;
      else if (shift_in[22:15] != ADDR_TONE_DETECT_STATE)
      begin
        link_write <= {shift_in, i_command_data};
        link_write_toggle <= ~link_write_toggle;
      end
    end
  end

  // reply: load snapshot after address byte, then shift out
  always_ff @(posedge i_serial_clock or posedge i_select_n)
  begin
    if (i_select_n)
    begin
      reply_shift <= 16'h0000;
      reply_drive <= 1'b0;
    end
    else if (bit_count == ADDR_BITS - 5'h01)
    begin
      reply_drive <= (next_addr == ADDR_EVENT_FLAGS) || (next_addr == ADDR_TONE_DETECT_STATE);
      if (next_addr == ADDR_EVENT_FLAGS)
        reply_shift <= snap_flags;
      else if (next_addr == ADDR_TONE_DETECT_STATE)
        reply_shift <= snap_tone;
      else
        reply_shift <= 16'h0000;
    end
    else if (bit_count == FRAME_BITS - 5'h01)
      reply_drive <= 1'b0;
    else
      reply_shift <= {reply_shift[14:0], 1'b0};
  end

  assign o_reply_data = reply_shift[15];
  assign o_reply_oe = reply_drive;

  // ---
  // crossing into the core clock
  // ---
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic [1:0] sel_sync;
  logic wr_pulse;
  logic rd_pulse;
  dscr_write_t cmd;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
      sel_sync <= 2'h3;
      cmd <= '0;
    end
    else
    begin
      wr_sync <= {wr_sync[1:0], link_write_toggle};
      rd_sync <= {rd_sync[1:0], link_read_toggle};
      sel_sync <= {sel_sync[0], i_select_n};
      if (wr_sync[2] != wr_sync[1])
        cmd <= link_write;
    end
  end

  assign wr_pulse = wr_sync[2] != wr_sync[1];
  assign rd_pulse = rd_sync[2] != rd_sync[1];

  logic wr_valid;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wr_valid <= 1'b0;
    else
      wr_valid <= wr_pulse;
  end

  function automatic logic is_write(input dscr_write_t c, input logic [7:0] a);
    is_write = c.addr == a;
  endfunction : is_write

  // ---
  // modem setup and transmit word
  // ---
  dscr_modem_setup_t modem_setup;
  dscr_tx_word_t tx_pending;
  logic tx_loaded;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      modem_setup <= MODEM_SETUP_RESET;
    else if (wr_valid && is_write(cmd, ADDR_MODEM_SETUP))
      modem_setup <= cmd.data;
  end

  // direct out, dsc mode, last-data passed as written
  assign o_modem_setup = modem_setup;
  assign o_sync_search = modem_setup.dsc_mode && modem_setup.raw_mode && i_rx_mode;

  // repeat current word unless a new one waits
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_pending <= TX_WORD_RESET;
      tx_loaded <= 1'b0;
      o_tx_word <= TX_WORD_RESET;
    end
    else
    begin
      if (wr_valid && is_write(cmd, ADDR_TRANSMIT_WORD))
      begin
        tx_pending <= cmd.data;
        tx_loaded <= 1'b1;
      end
      else if (i_word_sent)
        tx_loaded <= 1'b0;
      if (i_word_sent && tx_loaded)
        o_tx_word <= tx_pending;
    end
  end

  // flagged characters skipped in formatted mode
  // raw mode sends the whole word
  assign o_tx_char_send = modem_setup.raw_mode ? 2'b11 : {~o_tx_word.skip0, ~o_tx_word.skip1};

  // ---
  // block load port
  // ---
  logic load_port_ready;
  logic load_wr;
  assign load_wr = wr_valid && is_write(cmd, ADDR_BLOCK_LOAD_PORT);

  // ready flag cleared by write, set when action done
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      load_port_ready <= 1'b1;
    else if (load_wr)
      load_port_ready <= 1'b0;
    else if (i_load_done)
      load_port_ready <= 1'b1;
  end

  // select resets pointer, plain write advances it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_load_block <= BLOCK_RESET;
      o_load_word_ptr <= WORD_PTR_RESET;
      o_load_data <= 16'h0000;
      o_load_write <= 1'b0;
    end
    else
    begin
      o_load_write <= load_wr;
      if (load_wr)
      begin
        o_load_data <= cmd.data;
        if (cmd.data[LOAD_SELECT_BIT])
        begin
          o_load_block <= cmd.data[14] ? {1'b0, cmd.data[13:12]} : 3'h4;
          o_load_word_ptr <= WORD_PTR_RESET;
        end
        else
          o_load_word_ptr <= o_load_word_ptr + 4'h1;
      end
    end
  end

  // ---
  // tone and gain multiplexed register
  // ---
  logic mux_wr;
  logic [3:0] sel;
  logic [11:0] last_level_write;
  logic level_from_load;
  assign mux_wr = wr_valid && is_write(cmd, ADDR_TONE_AND_GAIN_MUX);
  assign sel = cmd.data[15:12];
  assign level_from_load = load_wr && cmd.data[15:12] == LOAD_LEVEL_PREFIX;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_tone_freq <= TONE_FREQ_RESET;
    else if (mux_wr && sel == SEL_TONE_FREQ)
      o_tone_freq <= cmd.data[11:0];
  end

  assign o_tone_active = i_tone_enable && o_tone_freq != 12'h000;

  // last writer wins, repeat value ignored
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tone_level <= LEVEL_UNITY;
      last_level_write <= LEVEL_UNITY;
      o_tone_level_load <= 1'b0;
    end
    else
    begin
      o_tone_level_load <= 1'b0;
      if (mux_wr && sel == SEL_TONE_LEVEL)
      begin
        last_level_write <= cmd.data[11:0];
        if (cmd.data[11:0] != last_level_write)
        begin
          o_tone_level <= cmd.data[11:0];
          o_tone_level_load <= 1'b1;
        end
      end
      else if (level_from_load)
      begin
        o_tone_level <= cmd.data[11:0];
        o_tone_level_load <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_out1_gain <= LEVEL_UNITY;
      o_out2_gain <= LEVEL_UNITY;
      o_voice_mult <= VOICE_MULT_RESET;
      o_modulator_out_one_atten <= FINE_ATTEN_RESET;
      o_modulator_out_two_atten <= FINE_ATTEN_RESET;
    end
    else if (mux_wr)
    begin
      if (sel == SEL_OUT1_GAIN)
        o_out1_gain <= cmd.data[11:0];
      if (sel == SEL_OUT2_GAIN)
        o_out2_gain <= cmd.data[11:0];
      if (sel == SEL_VOICE_MULT && cmd.data[2:0] <= VOICE_MULT_MAX)
        o_voice_mult <= cmd.data[2:0];
      if (sel == SEL_FINE_ATTEN && cmd.data[3:0] <= FINE_ATTEN_MAX)
        o_modulator_out_one_atten <= cmd.data[3:0];
      if (sel == SEL_FINE_ATTEN && cmd.data[7:4] <= FINE_ATTEN_MAX)
        o_modulator_out_two_atten <= cmd.data[7:4];
    end
  end

  // ---
  // tone detect state
  // ---
  logic [15:0] tone_state;
  logic [15:0] next_tone_state;
  logic tone_changed;
  assign next_tone_state = {1'b0, i_tone_index, i_tone_valid, 10'h000};
  assign tone_changed = i_tone_update && ((next_tone_state ^ tone_state) & TONE_CHANGE_MASK) != 16'h0000;

  // identity until detector writes, index and valid
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tone_state <= DEVICE_IDENT;
    else if (i_tone_update)
      tone_state <= next_tone_state;
  end

  // ---
  // event flags and mask
  // ---
  logic [15:0] event_flags;
  logic [15:0] event_mask;
  logic [15:0] set_vec;
  logic [15:0] change_vec;
  logic prev_load_ready;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      event_mask <= EVENT_MASK_RESET;
    else if (wr_valid && is_write(cmd, ADDR_EVENT_ENABLE_MASK))
      event_mask <= cmd.data & (EV_USED_MASK | 16'h8000);
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prev_load_ready <= 1'b1;
    else
      prev_load_ready <= load_port_ready;
  end

  always_comb
  begin
    set_vec = 16'h0000;
    // data ready in tx on word boundary, in rx on new word
    set_vec[EV_DATA_READY] = (i_tx_mode && i_word_sent) || (i_rx_mode && i_rx_word_ready);
    set_vec[EV_DSC] = i_dsc_valid;
    set_vec[EV_DATA_END] = i_data_end;
    set_vec[EV_ADC1] = i_adc1_change;
    set_vec[EV_ADC2] = i_adc2_change;
    set_vec[EV_WEATHER] = i_weather_change;
    set_vec[EV_DTMF] = tone_changed;
    change_vec = set_vec;
    change_vec[EV_LOAD_READY] = load_port_ready && !prev_load_ready;
  end

  // read clears reported bits above 1; set beats clear
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      event_flags <= EVENT_FLAGS_RESET;
    else
    begin
      event_flags[14:1] <= (event_flags[14:1] & ~(rd_pulse ? snap_flags[14:1] & EV_READ_CLEAR_MASK[14:1] : 14'h0000))
        | set_vec[14:1];
      event_flags[EV_LOAD_READY] <= load_port_ready;
      event_flags[EV_SUMMARY] <= (event_flags[EV_SUMMARY] && !(rd_pulse && snap_flags[EV_SUMMARY]))
        || ((change_vec & event_mask) != 16'h0000);
    end
  end

  // pin low while summary and master enable
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_interrupt_pin_n <= 1'b1;
    else
      o_interrupt_pin_n <= !(event_flags[EV_SUMMARY] && event_mask[EV_SUMMARY]);
  end

  assign o_flags_valid = !i_powersave;

  // ---
  // read snapshot, frozen while link selected
  // ---
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      snap_flags <= EVENT_FLAGS_RESET;
      snap_tone <= DEVICE_IDENT;
    end
    else if (sel_sync[1])
    begin
      snap_flags <= event_flags;
      // tone state reads zero in tx mode
      snap_tone <= i_tx_mode ? 16'h0000 : tone_state;
    end
  end
endmodule : dscr_regs
`default_nettype wire

// ---- test/dscr_regs_assertions.sv ----
// checker: concurrent properties on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module dscr_regs_assertions
  import dscr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_powersave,
  input wire logic i_tone_enable,
  input wire logic i_rx_mode,
  input wire logic i_tx_mode,
  input wire logic i_word_sent,
  input wire dscr_pkg::dscr_modem_setup_t o_modem_setup,
  input wire logic o_sync_search,
  input wire logic o_flags_valid,
  input wire dscr_pkg::dscr_tx_word_t o_tx_word,
  input wire logic [1:0] o_tx_char_send,
  input wire logic o_load_write,
  input wire logic [15:0] o_load_data,
  input wire logic [3:0] o_load_word_ptr,
  input wire logic [11:0] o_tone_freq,
  input wire logic o_tone_active,
  input wire logic o_tone_level_load,
  input wire logic [2:0] o_voice_mult,
  input wire logic [3:0] o_modulator_out_one_atten,
  input wire logic [3:0] o_modulator_out_two_atten
);
  // ---
  // properties
  // ---
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_select;
    o_load_write && o_load_data[LOAD_SELECT_BIT];
  endsequence
  sequence s_step;
    o_load_write && !o_load_data[LOAD_SELECT_BIT];
  endsequence
  chk_flags_valid: assert property (o_flags_valid == !i_powersave)
    else $error("flags valid wrong");
  chk_tone_active: assert property (o_tone_active == (i_tone_enable && (o_tone_freq != 12'h000)))
    else $error("tone active wrong");
  chk_sync_search: assert property (o_sync_search == (o_modem_setup.dsc_mode && o_modem_setup.raw_mode && i_rx_mode))
    else $error("sync search wrong");
  chk_ptr_select: assert property (s_select |-> o_load_word_ptr == WORD_PTR_RESET)
    else $error("pointer not reset");
  chk_ptr_step: assert property (s_step |-> o_load_word_ptr == 4'($past(o_load_word_ptr) + 4'h1))
    else $error("pointer stuck");
  chk_load_pulse: assert property (o_load_write |=> !o_load_write)
    else $error("load write too long");
  chk_level_pulse: assert property (o_tone_level_load |=> !o_tone_level_load)
    else $error("level load too long");
  chk_tx_hold: assert property ($changed(o_tx_word) |-> $past(i_word_sent) || $past(i_word_sent, 2))
    else $error("tx word changed early");
  chk_char_skip: assert property (i_tx_mode && o_modem_setup.dsc_mode && !o_modem_setup.raw_mode
    |-> o_tx_char_send == {!o_tx_word.skip0, !o_tx_word.skip1})
    else $error("char not skipped");
  chk_mult_range: assert property (o_voice_mult <= VOICE_MULT_MAX)
    else $error("multiplier range");
  chk_atten_range: assert property (o_modulator_out_one_atten <= FINE_ATTEN_MAX
    && o_modulator_out_two_atten <= FINE_ATTEN_MAX)
    else $error("attenuator range");
endmodule : dscr_regs_assertions
`default_nettype wire

// ---- test/dscr_host_model.sv ----
// partner: host driving the serial register link
`timescale 1ns/1ps
`default_nettype none
module dscr_host_model
(
  output logic o_serial_clock,
  output logic o_select_n,
  output logic o_command_data,
  input wire logic i_reply_data
);
  // ---
  // frame transfer
  // ---
  initial
  begin
    o_serial_clock = 1'b0;
    o_select_n = 1'b1;
    o_command_data = 1'b0;
  end
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {a, d};
    q = 16'h0000;
    #300;
    o_select_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      o_command_data = f[i];
      #16;
      if (i < 16)
        q[i] = i_reply_data;
      o_serial_clock = 1'b1;
      #16;
      o_serial_clock = 1'b0;
    end
    o_command_data = ~o_command_data;
    #16;
    o_select_n = 1'b1;
  endtask : xfer
endmodule : dscr_host_model
`default_nettype wire

// ---- test/dscr_regs_tb_top.sv ----
// testbench: directed scenarios for the register bank
`timescale 1ns/1ps
`default_nettype none
module dscr_regs_tb_top;
  import dscr_pkg::*;
  logic i_clock, i_rst_n, i_tx_mode, i_rx_mode, i_powersave, i_tone_enable, i_tone_valid;
  logic [3:0] i_tone_index;
  logic [5:0] ev;
  logic [2:0] pu;
  logic [15:0] q;
  int num_errors = 0;
  int checks = 0;
  wire logic sclk, sel_n, sdo, rdo, roe, irq_n, o_sync_search, o_flags_valid, o_load_write;
  wire logic o_tone_active, o_tone_level_load;
  dscr_modem_setup_t o_modem_setup;
  dscr_tx_word_t o_tx_word;
  wire logic [1:0] o_tx_char_send;
  wire logic [15:0] o_load_data;
  wire logic [2:0] o_load_block, o_voice_mult;
  wire logic [3:0] o_load_word_ptr, a1, a2;
  wire logic [11:0] o_tone_freq, o_tone_level, g1, g2;
  dscr_host_model dscr_host_model_i (.o_serial_clock(sclk), .o_select_n(sel_n), .o_command_data(sdo),
    .i_reply_data(rdo));
  dscr_regs dscr_regs_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_clock(sclk), .i_select_n(sel_n),
    .i_command_data(sdo), .o_reply_data(rdo), .o_reply_oe(roe), .o_interrupt_pin_n(irq_n),
    .i_tx_mode(i_tx_mode), .i_rx_mode(i_rx_mode), .i_powersave(i_powersave), .i_tone_enable(i_tone_enable),
    .i_dsc_valid(ev[0]), .i_rx_word_ready(ev[1]), .i_data_end(ev[2]), .i_weather_change(ev[3]),
    .i_adc1_change(ev[4]), .i_adc2_change(ev[5]), .i_load_done(pu[0]), .i_tone_update(pu[1]),
    .i_tone_valid(i_tone_valid), .i_tone_index(i_tone_index), .i_word_sent(pu[2]),
    .o_modem_setup(o_modem_setup), .o_sync_search(o_sync_search), .o_flags_valid(o_flags_valid),
    .o_tx_word(o_tx_word), .o_tx_char_send(o_tx_char_send), .o_load_write(o_load_write),
    .o_load_data(o_load_data), .o_load_block(o_load_block), .o_load_word_ptr(o_load_word_ptr),
    .o_tone_freq(o_tone_freq), .o_tone_active(o_tone_active), .o_tone_level(o_tone_level),
    .o_tone_level_load(o_tone_level_load), .o_out1_gain(g1), .o_out2_gain(g2), .o_voice_mult(o_voice_mult),
    .o_modulator_out_one_atten(a1), .o_modulator_out_two_atten(a2));
  // ---
  // helpers
  // ---
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    dscr_host_model_i.xfer(a, d, r);
    repeat (6) @(posedge i_clock);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    dscr_host_model_i.xfer(a, 16'h0000, q);
    repeat (6) @(posedge i_clock);
  endtask : rd
  task automatic pulse(input logic [5:0] e, input logic [2:0] p);
    @(posedge i_clock);
    ev <= e;
    pu <= p;
    @(posedge i_clock);
    ev <= 6'h00;
    pu <= 3'h0;
    repeat (3) @(posedge i_clock);
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ---
  // scenarios
  // ---
  task automatic t_reset;
    rd(ADDR_TONE_DETECT_STATE);
    chk("ident", q, DEVICE_IDENT);
    rd(ADDR_EVENT_FLAGS);
    chk("flags", q, EVENT_FLAGS_RESET);
    chk("level", {4'h0, o_tone_level}, {4'h0, LEVEL_UNITY});
    chk("gain2", {4'h0, g2}, {4'h0, LEVEL_UNITY});
    chk("mult", {13'h0, o_voice_mult}, {13'h0, VOICE_MULT_RESET});
    $display("test reset done");
  endtask : t_reset
  task automatic t_events;
    @(posedge i_clock);
    i_rx_mode <= 1'b1;
    wr(ADDR_EVENT_ENABLE_MASK, 16'hC3C9);
    pulse(6'h3F, 3'h0);
    chk("pin", {15'h0, irq_n}, 16'h0000);
    rd(ADDR_EVENT_FLAGS);
    chk("flags", q, 16'hC3C9);
    rd(ADDR_EVENT_FLAGS);
    chk("cleared", q, 16'h0001);
    chk("pin", {15'h0, irq_n}, 16'h0001);
    i_powersave <= 1'b1;
    @(posedge i_clock);
    @(posedge i_clock);
    chk("valid", {15'h0, o_flags_valid}, 16'h0000);
    i_powersave <= 1'b0;
    $display("test events done");
  endtask : t_events
  task automatic t_load;
    wr(ADDR_BLOCK_LOAD_PORT, 16'h8000);
    chk("block", {o_load_block, o_load_word_ptr}, 7'h40);
    rd(ADDR_EVENT_FLAGS);
    chk("ready", q & 16'h0001, 16'h0000);
    pulse(6'h00, 3'h1);
    rd(ADDR_EVENT_FLAGS);
    chk("ready", q & 16'h0001, 16'h0001);
    wr(ADDR_BLOCK_LOAD_PORT, 16'h0123);
    chk("step", {o_load_data, o_load_word_ptr}, 20'h01231);
    pulse(6'h00, 3'h1);
    wr(ADDR_BLOCK_LOAD_PORT, 16'hF000);
    chk("block", {o_load_block, o_load_word_ptr}, 7'h30);
    pulse(6'h00, 3'h1);
    $display("test load done");
  endtask : t_load
  task automatic t_tone;
    i_tone_enable <= 1'b1;
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h01B8);
    chk("freq", {o_tone_active, o_tone_freq}, 13'h11B8);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h0000);
    chk("bias", {o_tone_active, o_tone_freq}, 13'h0000);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h2123);
    wr(ADDR_BLOCK_LOAD_PORT, 16'hD456);
    chk("level", {4'h0, o_tone_level}, 16'h0456);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h2123);
    chk("same", {4'h0, o_tone_level}, 16'h0456);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h2124);
    chk("differ", {4'h0, o_tone_level}, 16'h0124);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h6ABC);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'h8DEF);
    chk("gains", {g1, g2}, 24'hABCDEF);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'hA005);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'hA006);
    chk("mult", {13'h0, o_voice_mult}, 16'h0005);
    wr(ADDR_TONE_AND_GAIN_MUX, 16'hC095);
    chk("atten", {a2, a1}, 8'h95);
    wr(8'hD0, 16'h0321);
    chk("unmapped", {4'h0, o_tone_freq}, 16'h0000);
    $display("test tone done");
  endtask : t_tone
  task automatic t_state;
    i_tone_valid <= 1'b1;
    i_tone_index <= 4'h5;
    pulse(6'h00, 3'h2);
    rd(ADDR_TONE_DETECT_STATE);
    chk("tone", q & TONE_CHANGE_MASK, 16'h2C00);
    rd(ADDR_EVENT_FLAGS);
    chk("dtmf", q & 16'h1000, 16'h1000);
    i_rx_mode <= 1'b0;
    i_tx_mode <= 1'b1;
    rd(ADDR_TONE_DETECT_STATE);
    chk("txzero", q, 16'h0000);
    $display("test state done");
  endtask : t_state
  task automatic t_tx;
    wr(ADDR_MODEM_SETUP, 16'h0800);
    chk("setup", o_modem_setup, 16'h0800);
    wr(ADDR_TRANSMIT_WORD, 16'h8141);
    chk("current", o_tx_word, TX_WORD_RESET);
    pulse(6'h00, 3'h4);
    chk("next", o_tx_word, 16'h8141);
    chk("skip", {14'h0, o_tx_char_send}, 16'h0001);
    rd(ADDR_EVENT_FLAGS);
    chk("ready", q & 16'h0040, 16'h0040);
    pulse(6'h00, 3'h4);
    chk("repeat", o_tx_word, 16'h8141);
    // last data set after the final load request
    wr(ADDR_MODEM_SETUP, 16'h0A00);
    chk("last", o_modem_setup, 16'h0A00);
    i_tx_mode <= 1'b0;
    i_rx_mode <= 1'b1;
    wr(ADDR_MODEM_SETUP, 16'h0C00);
    chk("search", {15'h0, o_sync_search}, 16'h0001);
    chk("raw", {14'h0, o_tx_char_send}, 16'h0003);
    wr(ADDR_MODEM_SETUP, 16'h1000);
    chk("direct", o_modem_setup, 16'h1000);
    $display("test tx done");
  endtask : t_tx
  // ---
  // clock, reset, sequence, watchdog
  // ---
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial
  begin
    {i_rst_n, i_tx_mode, i_rx_mode, i_powersave, i_tone_enable, i_tone_valid} = 6'h00;
    i_tone_index = 4'h0;
    ev = 6'h00;
    pu = 3'h0;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    t_reset;
    t_events;
    t_load;
    t_tone;
    t_state;
    t_tx;
    end_sim;
  end
  initial
  begin
    #1000000;
    num_errors++;
    end_sim;
  end
endmodule : dscr_regs_tb_top
bind dscr_regs dscr_regs_assertions dscr_regs_assertions_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_powersave(i_powersave), .i_tone_enable(i_tone_enable), .i_rx_mode(i_rx_mode), .i_tx_mode(i_tx_mode),
  .i_word_sent(i_word_sent), .o_modem_setup(o_modem_setup), .o_sync_search(o_sync_search),
  .o_flags_valid(o_flags_valid), .o_tx_word(o_tx_word), .o_tx_char_send(o_tx_char_send),
  .o_load_write(o_load_write), .o_load_data(o_load_data), .o_load_word_ptr(o_load_word_ptr),
  .o_tone_freq(o_tone_freq), .o_tone_active(o_tone_active), .o_tone_level_load(o_tone_level_load),
  .o_voice_mult(o_voice_mult), .o_modulator_out_one_atten(o_modulator_out_one_atten),
  .o_modulator_out_two_atten(o_modulator_out_two_atten));
`default_nettype wire
